// ==== hw/ref_defs.svh ====
// Offsets, reset values, ranges and timing counts of the rotor earth fault logic
`ifndef REF_DEFS_SVH
`define REF_DEFS_SVH

`define REF_OFS_MODE 12'h000
`define REF_OFS_WARN_THR 12'h004
`define REF_OFS_WARN_DLY 12'h008
`define REF_OFS_TRIP_THR 12'h00c
`define REF_OFS_TRIP_DLY 12'h010
`define REF_OFS_UE_THR 12'h014
`define REF_OFS_UE_DLY 12'h018
`define REF_OFS_POS_CPL 12'h01c
`define REF_OFS_NEG_CPL 12'h020
`define REF_OFS_STATUS 12'h024
`define REF_OFS_FAULT_RES 12'h028
`define REF_OFS_LOCATION 12'h02c
`define REF_OFS_EXC_VOLT 12'h030
`define REF_OFS_POS_CAL 12'h034
`define REF_OFS_NEG_CAL 12'h038

`define REF_RST_RES_THR 20'h02710
`define REF_RST_DLY 16'h07d0
`define REF_RST_UE_THR 11'h0c8
`define REF_RST_CPL 20'h09c40

`define REF_RES_MIN 20'h00fa0
`define REF_RES_MAX 20'h09c40
`define REF_UE_MIN 11'h032
`define REF_UE_MAX 11'h514
`define REF_DLY_MIN 16'h03e8
`define REF_DLY_MAX 16'hfa00

`define REF_AUX_LIMIT 11'h032
`define REF_RES_HYST_OHM 24'h0003e8
`define REF_LOC_MAX 10'h064
`define REF_LOC_BAD 10'h3e7
`define REF_PICK_SAMPLES 2'h2

`define REF_CLK_NS 10
`define REF_MS_NS 1000000
`define REF_MS_CYCLES (`REF_MS_NS / `REF_CLK_NS)

`endif

// ==== hw/ref_event.sv ====
// Turns level changes of the six stage flags into single on/off events
`timescale 1ns/100ps
module ref_event #(
  parameter int N = 6
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Flags watched
  input wire logic [N-1:0] flags,
  // Event stream
  output logic event_valid_q,
  output logic [2:0] event_id_q,
  output logic event_value_q
);
  logic [N-1:0] prev_q;
  logic [N-1:0] pend_q;
  logic [N-1:0] pick;
  logic [2:0] idx;

  always_comb begin
    pick = '0;
    idx = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        pick = '0;
        pick[i] = 1'b1;
        idx = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      pend_q <= '0;
      event_valid_q <= 1'b0;
      event_id_q <= 3'h0;
      event_value_q <= 1'b0;
    end else begin
      prev_q <= flags;
      pend_q <= (pend_q & ~pick) | (flags ^ prev_q);
      event_valid_q <= |pend_q;
      event_id_q <= idx;
      event_value_q <= |(flags & pick);
    end
  end
endmodule : ref_event

// ==== hw/ref_pkg.sv ====
// Types of the rotor earth fault logic
package ref_pkg;
  typedef enum logic [1:0] {
    REF_MODE_OFF,
    REF_MODE_DUAL_POLE,
    REF_MODE_SINGLE_POINT,
    REF_MODE_CALIBRATION
  } ref_mode_e;
  typedef logic [19:0] ref_res_t;
  typedef logic [10:0] ref_volt_t;
  typedef logic [15:0] ref_dly_t;
endpackage : ref_pkg

// ==== hw/ref_stage.sv ====
// One protection stage: pickup with reset hysteresis and a delay timer
`timescale 1ns/100ps
`include "ref_defs.svh"
module ref_stage
  import ref_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic sample,
  input wire logic pick_cond,
  input wire logic reset_cond,
  input wire logic ms_tick,
  input wire ref_dly_t delay,
  // Flags
  output logic start_q,
  output logic timeout_q
);
  logic [1:0] run_q;
  logic [1:0] run_d;
  ref_dly_t ms_q;
  wire logic want = start_q ? reset_cond : pick_cond;
  wire logic flip = sample && want && (run_q == (`REF_PICK_SAMPLES - 2'h1));
  wire logic timed = start_q && (ms_q >= delay);

  assign run_d = !sample ? run_q : (!want || flip) ? 2'h0 : run_q + 2'h1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
      run_q <= 2'h0;
    end else if (!enable) begin
      start_q <= 1'b0;
      run_q <= 2'h0;
    end else begin
      run_q <= run_d;
      if (flip) begin
        start_q <= !start_q;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ms_q <= 16'h0000;
      timeout_q <= 1'b0;
    end else if (!enable || !start_q) begin
      ms_q <= 16'h0000;
      timeout_q <= 1'b0;
    end else begin
      if (ms_tick && !timed) begin
        ms_q <= ms_q + 16'h0001;
      end
      timeout_q <= timed;
    end
  end
endmodule : ref_stage

// ==== hw/ref_top.sv ====
// Rotor earth fault stage logic with its APB register file
// Notes on behaviour
// - Warning start follows warning stage pickup
// - Trip start follows trip stage pickup
// - Overvoltage start follows overvoltage stage pickup
// - Warning timeout after warning delay elapses
// - Trip timeout after trip delay elapses
// - Overvoltage timeout after its delay elapses
// - Invalid if supply wrong for injection state, in dual pole and single point only
// - Unrealistic location reads as 999
// - Location and voltage only in dual pole
// - Event on every start/timeout change
// - Pickup and reset take two half periods
// - Reset above 1.1x+1000 ohm, below 0.9x
// - Delay timer starts when start asserts
// - Thresholds kept within their allowed ranges
// - Location is 0-100 percent from positive
// - Calibration publishes both coupling resistances
// - Mode selects off, dual, single, calibration
// - Delays kept within 1000-64000 ms
`timescale 1ns/100ps
`include "ref_defs.svh"
module ref_top
  import ref_pkg::*;
#(
  parameter int MS_CYCLES = `REF_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements, one strobe per half period
  input wire logic meas_strobe,
  input wire ref_res_t fault_resistance,
  input wire ref_volt_t excitation_voltage,
  input wire ref_volt_t aux_supply_voltage,
  input wire logic injection_connected,
  input wire logic [9:0] location_raw,
  input wire ref_res_t positive_coupling_resistance,
  input wire ref_res_t negative_coupling_resistance,
  // Binary logic
  input wire logic function_block_input,
  output logic warning_start_flag,
  output logic trip_start_flag,
  output logic overvoltage_start_flag,
  output logic warning_timeout_flag,
  output logic trip_timeout_flag,
  output logic overvoltage_timeout_flag,
  output logic measurement_invalid_flag,
  // Events
  output logic event_valid,
  output logic [2:0] event_id,
  output logic event_value
);
  function automatic ref_res_t clamp_res(input logic [31:0] v);
    if (v[19:0] < `REF_RES_MIN || v[31:20] != 12'h000) begin
      clamp_res = (v[31:20] != 12'h000) ? `REF_RES_MAX : `REF_RES_MIN;
    end else if (v[19:0] > `REF_RES_MAX) begin
      clamp_res = `REF_RES_MAX;
    end else begin
      clamp_res = v[19:0];
    end
  endfunction : clamp_res

  function automatic ref_dly_t clamp_dly(input logic [31:0] v);
    if (v[31:16] != 16'h0000 || v[15:0] > `REF_DLY_MAX) begin
      clamp_dly = `REF_DLY_MAX;
    end else if (v[15:0] < `REF_DLY_MIN) begin
      clamp_dly = `REF_DLY_MIN;
    end else begin
      clamp_dly = v[15:0];
    end
  endfunction : clamp_dly

  function automatic logic res_pick(input ref_res_t r, input ref_res_t thr);
    res_pick = r < thr;
  endfunction : res_pick

  function automatic logic res_drop(input ref_res_t r, input ref_res_t thr);
    res_drop = ({4'h0, r} * 24'd10) > // 10*r vs 11*thr+10000
      ({4'h0, thr} * 24'd11 + `REF_RES_HYST_OHM * 24'd10);
  endfunction : res_drop

  ////////////////////////////////////////////////////////////////////////
  // Settings
  ref_mode_e mode_q;
  ref_res_t warn_thr_q;
  ref_res_t trip_thr_q;
  ref_volt_t ue_thr_q;
  ref_dly_t warn_dly_q;
  ref_dly_t trip_dly_q;
  ref_dly_t ue_dly_q;
  ref_res_t pos_cpl_q;
  ref_res_t neg_cpl_q;
  ref_res_t pos_cal_q;
  ref_res_t neg_cal_q;
  ref_res_t res_q;
  ref_volt_t ue_q;
  logic [9:0] loc_q;
  logic invalid_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [$clog2(MS_CYCLES+1)-1:0] pre_q;
  logic ms_tick_q;

  wire logic wr = psel && penable && pready_q && pwrite;
  wire logic setup = psel && !penable;
  wire logic dual = mode_q == REF_MODE_DUAL_POLE;
  wire logic prot = dual || mode_q == REF_MODE_SINGLE_POINT;
  wire logic stage_en = prot && !function_block_input;
  wire logic aux_low = aux_supply_voltage < `REF_AUX_LIMIT;
  wire logic aux_high = aux_supply_voltage > `REF_AUX_LIMIT;
  wire logic bad_aux = injection_connected ? aux_low : aux_high;
  wire logic good = meas_strobe && !bad_aux;
  wire logic ue_pick = excitation_voltage > ue_thr_q;
  wire logic [14:0] ue10 = {excitation_voltage, 3'h0} +
    {3'h0, excitation_voltage, 1'b0};
  wire logic [14:0] thr9 = {ue_thr_q, 3'h0} + {4'h0, ue_thr_q};
  wire logic ue_drop = ue10 < thr9;
  wire logic hit_mode = paddr == `REF_OFS_MODE;
  wire logic hit_warn_thr = paddr == `REF_OFS_WARN_THR;
  wire logic hit_warn_dly = paddr == `REF_OFS_WARN_DLY;
  wire logic hit_trip_thr = paddr == `REF_OFS_TRIP_THR;
  wire logic hit_trip_dly = paddr == `REF_OFS_TRIP_DLY;
  wire logic hit_ue_thr = paddr == `REF_OFS_UE_THR;
  wire logic hit_ue_dly = paddr == `REF_OFS_UE_DLY;
  wire logic hit_pos = paddr == `REF_OFS_POS_CPL;
  wire logic hit_neg = paddr == `REF_OFS_NEG_CPL;
  logic [31:0] rd;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // Read decode
  wire logic [5:0] flags = {overvoltage_timeout_flag, trip_timeout_flag,
    warning_timeout_flag, overvoltage_start_flag, trip_start_flag,
    warning_start_flag};
  always_comb begin
    rd_hit = 1'b1;
    if (hit_mode) begin
      rd = {30'h0, mode_q};
    end else if (hit_warn_thr) begin
      rd = {12'h0, warn_thr_q};
    end else if (hit_warn_dly) begin
      rd = {16'h0, warn_dly_q};
    end else if (hit_trip_thr) begin
      rd = {12'h0, trip_thr_q};
    end else if (hit_trip_dly) begin
      rd = {16'h0, trip_dly_q};
    end else if (hit_ue_thr) begin
      rd = {21'h0, ue_thr_q};
    end else if (hit_ue_dly) begin
      rd = {16'h0, ue_dly_q};
    end else if (hit_pos) begin
      rd = {12'h0, pos_cpl_q};
    end else if (hit_neg) begin
      rd = {12'h0, neg_cpl_q};
    end else if (paddr == `REF_OFS_STATUS) begin
      rd = {25'h0, measurement_invalid_flag, flags};
    end else if (paddr == `REF_OFS_FAULT_RES) begin
      rd = {12'h0, res_q};
    end else if (paddr == `REF_OFS_LOCATION) begin
      rd = {22'h0, dual ? loc_q : 10'h0};
    end else if (paddr == `REF_OFS_EXC_VOLT) begin
      rd = {21'h0, dual ? ue_q : 11'h0};
    end else if (paddr == `REF_OFS_POS_CAL) begin
      rd = {12'h0, pos_cal_q};
    end else if (paddr == `REF_OFS_NEG_CAL) begin
      rd = {12'h0, neg_cal_q};
    end else begin
      rd = 32'h0;
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !rd_hit;
      prdata_q <= (setup && !pwrite) ? rd : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= REF_MODE_OFF;
      warn_thr_q <= `REF_RST_RES_THR;
      trip_thr_q <= `REF_RST_RES_THR;
      ue_thr_q <= `REF_RST_UE_THR;
      warn_dly_q <= `REF_RST_DLY;
      trip_dly_q <= `REF_RST_DLY;
      ue_dly_q <= `REF_RST_DLY;
      pos_cpl_q <= `REF_RST_CPL;
      neg_cpl_q <= `REF_RST_CPL;
    end else if (wr) begin
      if (hit_mode) begin
        mode_q <= ref_mode_e'(pwdata[1:0]);
      end
      if (hit_warn_thr) begin
        warn_thr_q <= clamp_res(pwdata);
      end
      if (hit_trip_thr) begin
        trip_thr_q <= clamp_res(pwdata);
      end
      if (hit_ue_thr) begin
        ue_thr_q <= (pwdata > 32'(`REF_UE_MAX)) ? `REF_UE_MAX :
          (pwdata < 32'(`REF_UE_MIN)) ? `REF_UE_MIN : pwdata[10:0];
      end
      if (hit_warn_dly) begin
        warn_dly_q <= clamp_dly(pwdata);
      end
      if (hit_trip_dly) begin
        trip_dly_q <= clamp_dly(pwdata);
      end
      if (hit_ue_dly) begin
        ue_dly_q <= clamp_dly(pwdata);
      end
      if (hit_pos) begin
        pos_cpl_q <= pwdata[19:0];
      end
      if (hit_neg) begin
        neg_cpl_q <= pwdata[19:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Measured values
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_q <= 20'h0;
      ue_q <= 11'h0;
      loc_q <= 10'h0;
      pos_cal_q <= 20'h0;
      neg_cal_q <= 20'h0;
      invalid_q <= 1'b0;
    end else if (meas_strobe) begin
      invalid_q <= prot && bad_aux;
      res_q <= fault_resistance;
      ue_q <= dual ? excitation_voltage : 11'h0;
      loc_q <= !dual ? 10'h0 : (location_raw > `REF_LOC_MAX) ?
        `REF_LOC_BAD : location_raw;
      if (mode_q == REF_MODE_CALIBRATION) begin
        pos_cal_q <= positive_coupling_resistance;
        neg_cal_q <= negative_coupling_resistance;
      end
    end
  end
  assign measurement_invalid_flag = invalid_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= pre_q == ($bits(pre_q))'(MS_CYCLES - 1);
      pre_q <= (pre_q == ($bits(pre_q))'(MS_CYCLES - 1)) ? '0 :
        pre_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stages
  ref_stage u_warn (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(stage_en),
    .sample(good),
    .pick_cond(res_pick(fault_resistance, warn_thr_q)),
    .reset_cond(res_drop(fault_resistance, warn_thr_q)),
    .ms_tick(ms_tick_q),
    .delay(warn_dly_q),
    .start_q(warning_start_flag),
    .timeout_q(warning_timeout_flag)
  );

  ref_stage u_trip (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(stage_en),
    .sample(good),
    .pick_cond(res_pick(fault_resistance, trip_thr_q)),
    .reset_cond(res_drop(fault_resistance, trip_thr_q)),
    .ms_tick(ms_tick_q),
    .delay(trip_dly_q),
    .start_q(trip_start_flag),
    .timeout_q(trip_timeout_flag)
  );

  ref_stage u_ue (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(stage_en && dual),
    .sample(good),
    .pick_cond(ue_pick),
    .reset_cond(ue_drop),
    .ms_tick(ms_tick_q),
    .delay(ue_dly_q),
    .start_q(overvoltage_start_flag),
    .timeout_q(overvoltage_timeout_flag)
  );

  ref_event #(
    .N(6)
  ) u_event (
    .clk_sys(clk_sys),
    .rst(rst),
    .flags(flags),
    .event_valid_q(event_valid),
    .event_id_q(event_id),
    .event_value_q(event_value)
  );
endmodule : ref_top

// ==== tb/ref_logic_model.sv ====
// Far side model: binary logic driving the block input, event recorder
`timescale 1ns/100ps
module ref_logic_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request from the bench
  input wire logic block_req,
  // Event stream
  input wire logic event_valid,
  input wire logic [2:0] event_id,
  input wire logic event_value,
  // Results
  output logic function_block_input,
  output logic [5:0] ev_level,
  output int ev_count
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      function_block_input <= 1'b0;
      ev_level <= 6'h00;
      ev_count <= 0;
    end else begin
      function_block_input <= block_req;
      if (event_valid && event_id < 3'h6) begin
        ev_level[event_id] <= event_value;
        ev_count <= ev_count + 1;
      end
    end
  end
endmodule : ref_logic_model

// ==== tb/ref_top_asserts.sv ====
// Checker on the ports of the rotor earth fault logic
`timescale 1ns/100ps
module ref_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stages
  input wire logic meas_strobe,
  input wire logic function_block_input,
  input wire logic warning_start_flag,
  input wire logic trip_start_flag,
  input wire logic overvoltage_start_flag,
  input wire logic warning_timeout_flag,
  input wire logic trip_timeout_flag,
  input wire logic overvoltage_timeout_flag,
  input wire logic measurement_invalid_flag,
  // Events
  input wire logic event_valid,
  input wire logic [2:0] event_id,
  input wire logic event_value
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence held_blocked;
    function_block_input [*3];
  endsequence
  sequence warn_on_event;
    event_valid && event_id == 3'h0 && event_value;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_pready_answer: assert property (apb_setup |=> pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_warn_start_src: assert property (
    $rose(warning_start_flag) |-> $past(meas_strobe))
    else $error("warning start not after strobe");
  a_trip_start_src: assert property (
    $rose(trip_start_flag) |-> $past(meas_strobe))
    else $error("trip start not after strobe");
  a_ue_start_src: assert property (
    $rose(overvoltage_start_flag) |-> $past(meas_strobe))
    else $error("overvoltage start not after strobe");
  a_warn_timeout_src: assert property (
    $rose(warning_timeout_flag) |-> $past(warning_start_flag, 8))
    else $error("warning timeout without start");
  a_trip_timeout_src: assert property (
    $rose(trip_timeout_flag) |-> $past(trip_start_flag, 8))
    else $error("trip timeout without start");
  a_ue_timeout_src: assert property (
    $rose(overvoltage_timeout_flag) |-> $past(overvoltage_start_flag, 8))
    else $error("overvoltage timeout without start");
  a_block_clears: assert property (held_blocked |-> {
    warning_start_flag, trip_start_flag, overvoltage_start_flag,
    warning_timeout_flag, trip_timeout_flag,
    overvoltage_timeout_flag} == 6'h00)
    else $error("flags active while blocked");
  a_event_follows: assert property (
    $rose(warning_start_flag) |-> ##[1:8] warn_on_event)
    else $error("no event for warning start");
  a_invalid_strobe: assert property (
    !$stable(measurement_invalid_flag) |-> $past(meas_strobe))
    else $error("invalid flag changed without strobe");
endmodule : ref_top_chk

bind ref_top ref_top_chk ref_top_chk_inst (
  .clk_sys, .rst, .psel, .penable, .prdata, .pready, .pslverr,
  .meas_strobe, .function_block_input, .warning_start_flag,
  .trip_start_flag, .overvoltage_start_flag, .warning_timeout_flag,
  .trip_timeout_flag, .overvoltage_timeout_flag, .measurement_invalid_flag,
  .event_valid, .event_id, .event_value
);

// ==== tb/ref_top_tb.sv ====
// Self-checking bench of the rotor earth fault logic
`timescale 1ns/100ps
module ref_top_tb
  import ref_pkg::*;
();
  logic clk_sys, rst, psel, penable, pwrite, meas_strobe, blk_req, err;
  logic pready, pslverr, event_valid, event_value, function_block_input;
  logic injection_connected, measurement_invalid_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] event_id;
  logic [9:0] location_raw;
  logic [5:0] ev_level;
  wire [5:0] flags;
  ref_res_t fault_resistance, positive_coupling_resistance;
  ref_res_t negative_coupling_resistance;
  ref_volt_t excitation_voltage, aux_supply_voltage;
  int failures, samples_checked, ev_count, n;
  logic [11:0] ta [11] = '{12'h004, 12'h004, 12'h00c, 12'h00c, 12'h014,
    12'h014, 12'h014, 12'h008, 12'h008, 12'h010, 12'h018};
  int tv [11] = '{3999, 20000, 40001, 10000, 49, 1301, 200, 64001, 0, 0, 0};
  int te [11] = '{4000, 20000, 40000, 10000, 50, 1300, 200, 64000, 1000,
    1000, 1000};
  ////////////////////////////////////////////////////////////////////////////
  ref_top #(.MS_CYCLES(10)) ref_top_inst (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .meas_strobe, .fault_resistance, .excitation_voltage,
    .aux_supply_voltage, .injection_connected, .location_raw,
    .positive_coupling_resistance, .negative_coupling_resistance,
    .function_block_input, .measurement_invalid_flag,
    .warning_start_flag(flags[0]),
    .trip_start_flag(flags[1]),
    .overvoltage_start_flag(flags[2]),
    .warning_timeout_flag(flags[3]),
    .trip_timeout_flag(flags[4]),
    .overvoltage_timeout_flag(flags[5]),
    .event_valid, .event_id, .event_value
  );
  ref_logic_model ref_logic_model_inst (
    .clk_sys, .rst, .block_req(blk_req), .event_valid, .event_id,
    .event_value, .function_block_input, .ev_level, .ev_count
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (k = 0; pready !== 1'b1 && k < 20; k++) @(posedge clk_sys);
    if (k == 20) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic meas(input int cnt, input ref_res_t r, input ref_volt_t u,
                      input ref_volt_t s, input logic c, input logic [9:0] k);
    repeat (cnt) begin
      fault_resistance <= r;
      excitation_voltage <= u;
      aux_supply_voltage <= s;
      injection_connected <= c;
      location_raw <= k;
      meas_strobe <= 1'b1;
      @(posedge clk_sys);
      meas_strobe <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata, meas_strobe, blk_req} = '0;
    {fault_resistance, excitation_voltage, aux_supply_voltage} = '0;
    {injection_connected, location_raw} = '0;
    {positive_coupling_resistance, negative_coupling_resistance} = '0;
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rc(12'h004, 32'h00002710);
    rc(12'h008, 32'h000007d0);
    rc(12'h014, 32'h000000c8);
    rc(12'h01c, 32'h00009c40);
    rc(12'h000, 32'h00000000);
    apb(1'b0, 12'h03c, 32'h0);
    chk(32'(err), 32'h1);
    for (n = 0; n < 11; n++) begin
      apb(1'b1, ta[n], 32'(tv[n]));
      rc(ta[n], 32'(te[n]));
    end
    apb(1'b1, 12'h000, 32'h1);
    meas(1, 20'h03a98, 11'h000, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h0);
    meas(1, 20'h03a98, 11'h000, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h1);
    rc(12'h02c, 32'h32);
    meas(1, 20'h07530, 11'h000, 11'h028, 1'b1, 10'h032);
    meas(2, 20'h07530, 11'h000, 11'h03c, 1'b0, 10'h032);
    chk(32'(measurement_invalid_flag), 32'h1);
    chk(32'(flags), 32'h1);
    meas(2, 20'h059d8, 11'h000, 11'h000, 1'b0, 10'h096);
    chk(32'(measurement_invalid_flag), 32'h0);
    chk(32'(flags), 32'h1);
    rc(12'h02c, 32'h3e7);
    meas(2, 20'h059d9, 11'h000, 11'h000, 1'b0, 10'h032);
    chk(32'(flags), 32'h0);
    chk(32'(ev_count), 32'h2);
    apb(1'b1, 12'h000, 32'h2);
    rc(12'h02c, 32'h0);
    meas(2, 20'h07530, 11'h12c, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h0);
    rc(12'h030, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    meas(2, 20'h01388, 11'h12c, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    positive_coupling_resistance <= 20'h0a028;
    negative_coupling_resistance <= 20'h09858;
    meas(2, 20'h01388, 11'h12c, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h0);
    rc(12'h034, 32'h0a028);
    rc(12'h038, 32'h09858);
    apb(1'b1, 12'h01c, 32'h0a028);
    rc(12'h01c, 32'h0a028);
    apb(1'b1, 12'h000, 32'h1);
    meas(2, 20'h01388, 11'h12c, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h7);
    rc(12'h030, 32'h12c);
    repeat (9900) @(posedge clk_sys);
    chk(32'(flags), 32'h7);
    for (n = 0; flags !== 6'h3f && n < 300; n++) @(posedge clk_sys);
    chk(32'(flags), 32'h3f);
    if (n == 300) report_and_stop();
    repeat (8) @(posedge clk_sys);
    chk(32'(ev_level), 32'h3f);
    meas(2, 20'h01388, 11'h0b4, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h3f);
    meas(2, 20'h01388, 11'h0b3, 11'h064, 1'b1, 10'h032);
    chk(32'(flags), 32'h1b);
    blk_req <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(32'(flags), 32'h0);
    repeat (20) @(posedge clk_sys);
    chk(32'(ev_level), 32'h0);
    report_and_stop();
  end
endmodule : ref_top_tb
